// >>> ccs_regs.sv
// Charger current setpoint registers, bus target and temperature gate.
`default_nettype none
module ccs_regs #(
	parameter int STEP_CYCLES = ccs_pkg::CCS_STEP_CYC
) (
	input wire logic clock, // System clock, 50 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic scl_i, // Bus clock pin level.
	input wire logic sda_i, // Bus data pin level.
	output logic sda_o, // Bus data drive value, always low.
	output logic sda_oe, // Bus data pull-down enable.
	input wire logic temp_start_ok, // Sense pin between low and high thresholds.
	input wire logic temp_run_ok, // Sense pin between low and cutoff thresholds.
	output logic pwm_enable, // Both charge power switches allowed to run.
	output logic [6:0] charge_target, // Ramped charge current in 128 mA steps.
	output logic [6:0] input_limit_target // Input current limit in 128 mA steps.
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic scl_d;
		logic sda_d;
		ccs_pkg::ccs_bus_t bus;
		logic [2:0] cnt;
		logic done;
		logic [1:0] idx;
		logic rw;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] tx;
		logic hi_sent;
		logic oe;
		logic wr;
		logic [6:0] chg;
		logic [6:0] inp;
		ccs_pkg::ccs_chg_t cst;
		logic pwm;
		logic [6:0] ctgt;
	} ccs_st_t;

	ccs_st_t q;
	ccs_st_t n;
	ccs_ramp_if rif ();
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic en;
	logic [15:0] rd_word;
	logic [6:0] wr_step;

	// ****************************************
	// Pin events and read data
	// ****************************************
	// Only the second synchroniser stage and the delayed copy are looked at.
	assign scl_rise = q.s2[ccs_pkg::CCS_SY_SCL] & ~q.scl_d;
	assign scl_fall = ~q.s2[ccs_pkg::CCS_SY_SCL] & q.scl_d;
	assign bus_start = q.s2[ccs_pkg::CCS_SY_SCL] & q.scl_d & q.sda_d & ~q.s2[ccs_pkg::CCS_SY_SDA];
	assign bus_stop = q.s2[ccs_pkg::CCS_SY_SCL] & q.scl_d & ~q.sda_d & q.s2[ccs_pkg::CCS_SY_SDA];
	assign en = (q.chg != ccs_pkg::CCS_STEP_RST) && (q.inp != ccs_pkg::CCS_STEP_RST);

	// Read word: stored steps in their field, all other bits zero.
	always_comb begin
		rd_word = 16'h0000;
		if (q.cmd == ccs_pkg::CCS_CMD_CHG) begin
			rd_word[ccs_pkg::CCS_STEP_MSB:ccs_pkg::CCS_STEP_LSB] = q.chg;
		end else begin
			rd_word[ccs_pkg::CCS_STEP_MSB:ccs_pkg::CCS_STEP_LSB] = q.inp;
		end
	end

	// Written word to steps: low bits dropped, upper bits mean over range.
	always_comb begin
		if (|q.sh[ccs_pkg::CCS_OVR_MSB - 8:ccs_pkg::CCS_OVR_LSB - 8]) begin
			wr_step = ccs_pkg::CCS_STEP_MAX;
		end else begin
			wr_step = {q.sh[ccs_pkg::CCS_STEP_MSB - 8:0], q.lo[ccs_pkg::CCS_BYTE_LAST_BIT]};
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	// Bytes are sampled on the bus clock rise and the data line is changed only
	// after its fall, so the pull-down never moves while the clock is high.
	always_comb begin
		n = q;
		n.s1 = {temp_run_ok, temp_start_ok, sda_i, scl_i};
		n.s2 = q.s1;
		n.scl_d = q.s2[ccs_pkg::CCS_SY_SCL];
		n.sda_d = q.s2[ccs_pkg::CCS_SY_SDA];
		n.wr = 1'b0;
		if (bus_start) begin
			n.bus = ccs_pkg::CCS_BUS_RX;
			n.cnt = 3'h0;
			n.done = 1'b0;
			n.idx = ccs_pkg::CCS_IDX_ADDR;
			n.oe = 1'b0;
		end else if (bus_stop) begin
			n.bus = ccs_pkg::CCS_BUS_IDLE;
			n.oe = 1'b0;
		end else begin
			case (q.bus)
				ccs_pkg::CCS_BUS_RX: begin
					if (scl_rise && !q.done) begin
						n.sh = {q.sh[6:0], q.s2[ccs_pkg::CCS_SY_SDA]};
						n.cnt = q.cnt + 3'h1;
						n.done = (q.cnt == ccs_pkg::CCS_BIT_CNT_LAST);
					end
					if (scl_fall && q.done) begin
						n.done = 1'b0;
						n.cnt = 3'h0;
						n.oe = 1'b1;
						n.bus = ccs_pkg::CCS_BUS_ACK;
						case (q.idx)
							ccs_pkg::CCS_IDX_ADDR: begin
								if (q.sh[7:1] == ccs_pkg::CCS_BUS_ADDR[7:1]) begin
									n.rw = q.sh[0];
								end else begin
									n.oe = 1'b0;
									n.bus = ccs_pkg::CCS_BUS_IDLE;
								end
							end
							ccs_pkg::CCS_IDX_CMD: begin
								n.cmd = q.sh;
								if (q.sh != ccs_pkg::CCS_CMD_CHG && q.sh != ccs_pkg::CCS_CMD_INP) begin
									n.oe = 1'b0;
									n.bus = ccs_pkg::CCS_BUS_IDLE;
								end
							end
							ccs_pkg::CCS_IDX_DLO: begin
								n.lo = q.sh;
							end
							default: begin
								n.hi = q.sh;
								n.wr = 1'b1;
								if (q.cmd == ccs_pkg::CCS_CMD_CHG) begin
									n.chg = wr_step;
								end else begin
									n.inp = wr_step;
								end
							end
						endcase
					end
				end
				ccs_pkg::CCS_BUS_ACK: begin
					if (scl_fall) begin
						if (q.rw) begin
							n.tx = rd_word[7:0];
							n.oe = ~rd_word[ccs_pkg::CCS_BYTE_LAST_BIT];
							n.hi_sent = 1'b0;
							n.bus = ccs_pkg::CCS_BUS_TX;
						end else begin
							n.oe = 1'b0;
							n.idx = q.idx + 2'h1;
							n.bus = (q.idx == ccs_pkg::CCS_IDX_DHI) ? ccs_pkg::CCS_BUS_IDLE
								: ccs_pkg::CCS_BUS_RX;
						end
					end
				end
				ccs_pkg::CCS_BUS_TX: begin
					if (scl_fall) begin
						if (q.cnt == ccs_pkg::CCS_BIT_CNT_LAST) begin
							n.oe = 1'b0;
							n.bus = ccs_pkg::CCS_BUS_RACK;
						end else begin
							n.tx = {q.tx[6:0], 1'b0};
							n.oe = ~q.tx[6];
							n.cnt = q.cnt + 3'h1;
						end
					end
				end
				ccs_pkg::CCS_BUS_RACK: begin
					if (scl_rise) begin
						if (q.s2[ccs_pkg::CCS_SY_SDA] || q.hi_sent) begin
							n.bus = ccs_pkg::CCS_BUS_IDLE;
						end else begin
							n.done = 1'b1;
						end
					end
					if (scl_fall && q.done) begin
						n.done = 1'b0;
						n.cnt = 3'h0;
						n.tx = rd_word[15:8];
						n.oe = ~rd_word[15];
						n.hi_sent = 1'b1;
						n.bus = ccs_pkg::CCS_BUS_TX;
					end
				end
				default: begin
					n.oe = 1'b0;
				end
			endcase
		end

		// Temperature gate, judged anew every cycle.
		case (q.cst)
			ccs_pkg::CCS_CHG_OFF: begin
				if (en) begin
					n.cst = q.s2[ccs_pkg::CCS_SY_TST] ? ccs_pkg::CCS_CHG_RUN
						: ccs_pkg::CCS_CHG_WAIT;
				end
			end
			ccs_pkg::CCS_CHG_WAIT: begin
				if (!en) begin
					n.cst = ccs_pkg::CCS_CHG_OFF;
				end else if (q.s2[ccs_pkg::CCS_SY_TST]) begin
					n.cst = ccs_pkg::CCS_CHG_RUN;
				end
			end
			ccs_pkg::CCS_CHG_RUN: begin
				if (!en) begin
					n.cst = ccs_pkg::CCS_CHG_OFF;
				end else if (!q.s2[ccs_pkg::CCS_SY_TRN]) begin
					n.cst = ccs_pkg::CCS_CHG_WAIT;
				end
			end
			default: begin
				n.cst = ccs_pkg::CCS_CHG_OFF;
			end
		endcase
		n.pwm = (n.cst == ccs_pkg::CCS_CHG_RUN);
		n.ctgt = rif.level;
	end

	// State register; reset clears both setpoints and the gate.
	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
			q.bus <= ccs_pkg::CCS_BUS_IDLE;
			q.cst <= ccs_pkg::CCS_CHG_OFF;
		end else begin
			q <= n;
		end
	end

	// ****************************************
	// Soft start and outputs
	// ****************************************
	assign rif.run = q.pwm;
	assign rif.target = q.chg;

	ccs_soft_start #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_ramp (
		.clock(clock),
		.rst(rst),
		.rif(rif)
	);

	// Data is only ever pulled low; the enable alone carries the bit.
	assign sda_o = 1'b0;
	assign sda_oe = q.oe;
	assign pwm_enable = q.pwm;
	assign charge_target = q.ctgt;
	assign input_limit_target = q.inp;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_idle_quiet: assert property (q.bus == ccs_pkg::CCS_BUS_IDLE |-> !q.oe)
		else $error("Data line pulled while the bus target is idle.");
	chk_addr_only: assert property (q.bus == ccs_pkg::CCS_BUS_ACK && q.idx == ccs_pkg::CCS_IDX_ADDR
		|-> q.sh[7:1] == ccs_pkg::CCS_BUS_ADDR[7:1])
		else $error("Acknowledge given to a foreign address.");
	chk_cmd_known: assert property (q.bus == ccs_pkg::CCS_BUS_ACK && q.idx == ccs_pkg::CCS_IDX_CMD
		|-> q.cmd == ccs_pkg::CCS_CMD_CHG || q.cmd == ccs_pkg::CCS_CMD_INP)
		else $error("Unknown command acknowledged.");
	chk_chg_write: assert property (q.wr && q.cmd == ccs_pkg::CCS_CMD_CHG |-> q.chg ==
		((|q.hi[7:6]) ? ccs_pkg::CCS_STEP_MAX : {q.hi[5:0], q.lo[7]}))
		else $error("Charge setpoint stored wrongly.");
	chk_inp_write: assert property (q.wr && q.cmd == ccs_pkg::CCS_CMD_INP |-> q.inp ==
		((|q.hi[7:6]) ? ccs_pkg::CCS_STEP_MAX : {q.hi[5:0], q.lo[7]}))
		else $error("Input limit stored wrongly.");
	chk_zero_off: assert property (q.chg == 7'h00 || q.inp == 7'h00 |=> !q.pwm)
		else $error("Charging with a zero setpoint.");
	chk_start_band: assert property ($rose(q.pwm) |-> $past(q.s2[ccs_pkg::CCS_SY_TST]))
		else $error("Charging began outside the start band.");
	chk_run_band: assert property (q.pwm && !q.s2[ccs_pkg::CCS_SY_TRN] |=> !q.pwm ##1
		(!q.pwm || $past(q.s2[ccs_pkg::CCS_SY_TST])))
		else $error("Charging kept outside the run band.");
	chk_readback: assert property (q.bus == ccs_pkg::CCS_BUS_TX && q.cnt == 3'h0 && !q.hi_sent
		&& q.cmd == ccs_pkg::CCS_CMD_CHG |-> q.tx == {q.chg[0], 7'h00})
		else $error("Read data low byte wrong.");
	chk_reset_zero: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> q.chg == 7'h00 && q.inp == 7'h00 && !q.pwm)
		else $error("Setpoints not cleared by reset.");
endmodule : ccs_regs
`default_nettype wire

// >>> ccs_pkg.sv
// Package with the constants and types of the charger current setpoint block.
`default_nettype none
package ccs_pkg;
	// ****************************************
	// Bus addressing and command codes
	// ****************************************
	localparam logic [7:0] CCS_BUS_ADDR = 8'h12;
	localparam logic [7:0] CCS_CMD_CHG = 8'h14;
	localparam logic [7:0] CCS_CMD_INP = 8'h3F;
	localparam int CCS_BYTE_LAST_BIT = 7;
	localparam logic [2:0] CCS_BIT_CNT_LAST = 3'h7;
	localparam logic [1:0] CCS_IDX_ADDR = 2'h0;
	localparam logic [1:0] CCS_IDX_CMD = 2'h1;
	localparam logic [1:0] CCS_IDX_DLO = 2'h2;
	localparam logic [1:0] CCS_IDX_DHI = 2'h3;

	// ****************************************
	// Setpoint field layout
	// ****************************************
	localparam int CCS_STEP_W = 7;
	localparam int CCS_STEP_LSB = 7;
	localparam int CCS_STEP_MSB = 13;
	localparam int CCS_OVR_LSB = 14;
	localparam int CCS_OVR_MSB = 15;
	localparam logic [6:0] CCS_STEP_MAX = 7'h7F;
	localparam logic [6:0] CCS_STEP_RST = 7'h00;

	// ****************************************
	// Synchroniser bit positions
	// ****************************************
	localparam int CCS_SY_SCL = 0;
	localparam int CCS_SY_SDA = 1;
	localparam int CCS_SY_TST = 2;
	localparam int CCS_SY_TRN = 3;

	// ****************************************
	// Soft start timing
	// ****************************************
	localparam int CCS_CLK_NS = 20;
	localparam int CCS_STEP_TIME_NS = 1000000;
	localparam int CCS_STEP_CYC = CCS_STEP_TIME_NS / CCS_CLK_NS;
	localparam logic [3:0] CCS_RAMP_STEPS = 4'h8;
	localparam int CCS_RAMP_SHIFT = 3;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [4:0] {
		CCS_BUS_IDLE = 5'h01,
		CCS_BUS_RX = 5'h02,
		CCS_BUS_ACK = 5'h04,
		CCS_BUS_TX = 5'h08,
		CCS_BUS_RACK = 5'h10
	} ccs_bus_t;

	typedef enum logic [2:0] {
		CCS_CHG_OFF = 3'h1,
		CCS_CHG_WAIT = 3'h2,
		CCS_CHG_RUN = 3'h4
	} ccs_chg_t;
endpackage : ccs_pkg
`default_nettype wire

// >>> ccs_ramp_if.sv
// Interface between the setpoint logic and the soft start ramp.
`default_nettype none
interface ccs_ramp_if;
	logic run;
	logic [6:0] target;
	logic [6:0] level;
	modport ctl (output run, output target, input level);
	modport ramp (input run, input target, output level);
endinterface : ccs_ramp_if
`default_nettype wire

// >>> ccs_soft_start.sv
// Soft start ramp of the charge current target in eight timed steps.
`default_nettype none
module ccs_soft_start #(
	parameter int STEP_CYCLES = ccs_pkg::CCS_STEP_CYC
) (
	input wire logic clock, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	ccs_ramp_if.ramp rif // Run request, target and ramped level.
);
	typedef struct packed {
		logic [19:0] cnt;
		logic [3:0] k;
		logic [6:0] level;
	} ccs_ramp_st_t;

	ccs_ramp_st_t q;
	ccs_ramp_st_t n;
	logic [10:0] prod;

	// ****************************************
	// Ramp stepping
	// ****************************************
	// The level restarts from zero each time the run request rises, so a resume
	// after a suspend ramps again rather than jumping to the full target.
	always_comb begin
		n = q;
		prod = 11'(rif.target) * 11'(q.k);
		if (!rif.run) begin
			n.cnt = 20'h00000;
			n.k = 4'h0;
			n.level = 7'h00;
		end else begin
			if (q.k != ccs_pkg::CCS_RAMP_STEPS) begin
				if (q.cnt == 20'(STEP_CYCLES - 1)) begin
					n.cnt = 20'h00000;
					n.k = q.k + 4'h1;
				end else begin
					n.cnt = q.cnt + 20'h00001;
				end
			end
			n.level = prod[ccs_pkg::CCS_RAMP_SHIFT +: 7];
		end
	end

	// State register.
	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign rif.level = q.level;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_ramp_cap: assert property (q.level <= rif.target || $changed(rif.target))
		else $error("Ramp level above the programmed target.");
	chk_ramp_restart: assert property (!rif.run |=> q.level == 7'h00 && q.k == 4'h0)
		else $error("Ramp not restarted while stopped.");
	chk_ramp_hold: assert property (rif.run && q.k != ccs_pkg::CCS_RAMP_STEPS
		&& q.cnt != 20'(STEP_CYCLES - 1) |=> q.k == $past(q.k))
		else $error("Ramp step taken before its time.");
endmodule : ccs_soft_start
`default_nettype wire

// >>> ccs_host_model.sv
// Host bus master model that drives the setpoint block over its two-wire bus.
`default_nettype none
module ccs_host_model (
	input wire logic clock, // System clock.
	input wire logic sda, // Resolved data line level.
	output logic scl, // Bus clock, held high between frames.
	output logic sda_low // High while the host pulls data low.
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Bus cycles
	// ****************************************
	// The clock starts driven high and data starts released so the pull-up sets its idle level.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	// One bit; each half is ten clocks, above the three the target takes to answer a clock edge.
	task automatic bit_io(input logic b, output logic seen);
		sda_low <= !b;
		tick(5);
		scl <= 1'b1;
		tick(5);
		seen = sda;
		tick(5);
		scl <= 1'b0;
		tick(5);
	endtask : bit_io
	// Data falls while the clock is high; serves as repeated start too.
	task automatic start_bit();
		sda_low <= 1'b0;
		tick(5);
		scl <= 1'b1;
		tick(10);
		sda_low <= 1'b1;
		tick(10);
		scl <= 1'b0;
		tick(5);
	endtask : start_bit
	// Data rises while the clock is high, then the bus rests.
	task automatic stop_bit();
		sda_low <= 1'b1;
		tick(5);
		scl <= 1'b1;
		tick(10);
		sda_low <= 1'b0;
		tick(10);
	endtask : stop_bit
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask : put_byte
	// The host acknowledges every byte but the last one it reads.
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(last, s);
	endtask : get_byte
	// Word write, low byte first; acks returns one flag per byte.
	task automatic write_word(input logic [7:0] adr, input logic [7:0] cmd,
		input logic [15:0] d, output logic [3:0] acks);
		start_bit();
		put_byte(adr, acks[3]);
		put_byte(cmd, acks[2]);
		put_byte(d[7:0], acks[1]);
		put_byte(d[15:8], acks[0]);
		stop_bit();
	endtask : write_word
	// Word read through a repeated start with the read address.
	task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
		logic a;
		start_bit();
		put_byte(ccs_pkg::CCS_BUS_ADDR, a);
		put_byte(cmd, a);
		start_bit();
		put_byte(ccs_pkg::CCS_BUS_ADDR | 8'h01, a);
		get_byte(1'b0, d[7:0]);
		get_byte(1'b1, d[15:8]);
		stop_bit();
	endtask : read_word
endmodule : ccs_host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the charger current setpoint block.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STEP = 16;
	localparam logic [7:0] CHG = ccs_pkg::CCS_CMD_CHG;
	localparam logic [7:0] INP = ccs_pkg::CCS_CMD_INP;
	logic clock;
	logic rst;
	logic scl;
	logic sda_low;
	logic sda;
	logic sda_o;
	logic sda_oe;
	logic start_ok;
	logic run_ok;
	logic pwm_enable;
	logic [6:0] charge_target;
	logic [6:0] input_limit_target;
	logic [3:0] acks;
	int mismatches;
	int comparisons;
	// ****************************************
	// Harness
	// ****************************************
	// Open-drain data line with a pull-up, low when either side pulls.
	assign sda = !(sda_low || (sda_oe && !sda_o));
	ccs_regs #(.STEP_CYCLES(STEP)) ccs_regs_i (.clock(clock), .rst(rst), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .temp_start_ok(start_ok),
		.temp_run_ok(run_ok), .pwm_enable(pwm_enable), .charge_target(charge_target),
		.input_limit_target(input_limit_target));
	ccs_host_model ccs_host_model_i (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Waits end on the falling edge so register updates have landed.
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		ccs_host_model_i.write_word(ccs_pkg::CCS_BUS_ADDR, cmd, d, acks);
		check(16'(acks), 16'h000F);
		cyc(2);
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		logic [15:0] d;
		ccs_host_model_i.read_word(cmd, d);
		check(d, exp);
	endtask : rd
	task automatic temp(input logic s, input logic r);
		@(posedge clock);
		start_ok <= s;
		run_ok <= r;
		cyc(6);
	endtask : temp
	// Samples mid-step after the switches come on; a charge setpoint of 8 steps.
	task automatic ramp_chk();
		int n;
		n = 0;
		while (pwm_enable !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
		check(16'(pwm_enable), 16'h0001);
		cyc(STEP / 2);
		for (int k = 0; k <= 8; k++) begin
			check(16'(charge_target), 16'(k));
			cyc(STEP);
		end
	endtask : ramp_chk
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		check(16'(pwm_enable), 16'h0000);
		check(16'(charge_target), 16'h0000);
		rd(CHG, 16'h0000);
		rd(INP, 16'h0000);
	endtask : t_reset
	// Dropped bits, refused address and command, and a half-sent word.
	task automatic t_fields();
		wr(CHG, 16'h047F);
		rd(CHG, 16'h0400);
		check(16'(pwm_enable), 16'h0000);
		ccs_host_model_i.write_word(8'h20, CHG, 16'hFFFF, acks);
		check(16'(acks), 16'h0000);
		ccs_host_model_i.write_word(ccs_pkg::CCS_BUS_ADDR, 8'h15, 16'hFFFF, acks);
		check(16'(acks), 16'h0008);
		ccs_host_model_i.start_bit();
		ccs_host_model_i.put_byte(ccs_pkg::CCS_BUS_ADDR, acks[0]);
		ccs_host_model_i.put_byte(CHG, acks[0]);
		ccs_host_model_i.put_byte(8'h80, acks[0]);
		ccs_host_model_i.stop_bit();
		rd(CHG, 16'h0400);
		check(16'(sda_oe), 16'h0000);
	endtask : t_fields
	task automatic t_enable();
		wr(INP, 16'h0880);
		check(16'(input_limit_target), 16'h0011);
		cyc(10 * STEP);
		check(16'(pwm_enable), 16'h0001);
		check(16'(charge_target), 16'h0008);
	endtask : t_enable
	// Top of range, then values past it that must clamp and keep charging.
	task automatic t_clamp();
		wr(INP, 16'h3F80);
		check(16'(input_limit_target), 16'h007F);
		wr(INP, 16'h8000);
		rd(INP, 16'h3F80);
		check(16'(input_limit_target), 16'h007F);
		check(16'(pwm_enable), 16'h0001);
		wr(CHG, 16'h4000);
		rd(CHG, 16'h3F80);
		cyc(10 * STEP);
		check(16'(charge_target), 16'h007F);
		check(16'(pwm_enable), 16'h0001);
	endtask : t_clamp
	// A zero setpoint stops the switches; starting cold needs the start band.
	task automatic t_temp();
		wr(CHG, 16'h0000);
		check(16'(pwm_enable), 16'h0000);
		temp(1'b0, 1'b1);
		wr(CHG, 16'h0400);
		check(16'(pwm_enable), 16'h0000);
		@(posedge clock);
		start_ok <= 1'b1;
		ramp_chk();
		temp(1'b0, 1'b1);
		check(16'(pwm_enable), 16'h0001);
		temp(1'b0, 1'b0);
		check(16'(pwm_enable), 16'h0000);
		temp(1'b0, 1'b1);
		check(16'(pwm_enable), 16'h0000);
		@(posedge clock);
		start_ok <= 1'b1;
		ramp_chk();
	endtask : t_temp
	// ****************************************
	// Sequence and verdict
	// ****************************************
	task automatic final_report();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// Main sequence after a five-cycle reset.
	initial begin
		rst = 1'b1;
		start_ok = 1'b1;
		run_ok = 1'b1;
		mismatches = 0;
		comparisons = 0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		cyc(4);
		t_reset();
		t_fields();
		t_enable();
		t_clamp();
		t_temp();
		final_report();
	end
	// The run needs about 14000 cycles; a hang stops well past that.
	initial begin
		repeat (90000) @(posedge clock);
		mismatches++;
		final_report();
	end
endmodule : tb_top
`default_nettype wire
